// ### verilog/spcd_regs.vh
/*
 * constants for the serial programming instruction decoder: opcodes,
 * sub-codes, reset values and timing counts.
 * assumes inclusion by bare name from the decoder module.
 */
`ifndef SPCD_REGS_VH
`define SPCD_REGS_VH

`define SPCD_OP_ENABLE      8'hAC
`define SPCD_SUB_ENABLE     8'h53
`define SPCD_SUB_ERASE      8'h80
`define SPCD_SUB_WR_LOCK    8'hE0
`define SPCD_SUB_WR_FLO     8'hA0
`define SPCD_SUB_WR_FHI     8'hA8
`define SPCD_SUB_WR_FEXT    8'hA4
`define SPCD_OP_POLL        8'hF0
`define SPCD_OP_LD_EXT      8'h4D
`define SPCD_OP_LD_HI       8'h48
`define SPCD_OP_LD_LO       8'h40
`define SPCD_OP_LD_EE       8'hC1
`define SPCD_OP_RD_HI       8'h28
`define SPCD_OP_RD_LO       8'h20
`define SPCD_OP_RD_FUSE     8'h50
`define SPCD_OP_RD_LOCK     8'h58
`define SPCD_SUB_FUSE_ALT   8'h08
`define SPCD_OP_WR_PAGE     8'h4C
`define SPCD_OP_WR_EE_PAGE  8'hC2

// fuse and lock bytes reset to all unprogrammed
`define SPCD_FUSE_RST       8'hFF
`define SPCD_ERASED         8'hFF

// self-timed write and erase durations, microseconds
`define SPCD_T_WR_US        4500
`define SPCD_T_ERASE_US     9000
`define SPCD_CLK_MHZ        100

`endif

// ### verilog/spcd_decoder.v
/*
 * serial programming instruction decoder: shifts in four-byte
 * instructions on prog_serial_in, answers on prog_serial_out, and
 * drives page buffers, memory strobes, fuse and lock bytes.
 * assumes the programming clock and data come from outside the mclk
 * domain and are sampled here; memory arrays sit outside and answer
 * reads combinationally from mem_addr within one mclk cycle.
 * assumes the programming clock stays high and low for at least four
 * mclk cycles each, so that no edge is lost in the synchronisers.
 * fuse and lock bytes live in flops here; keeping them across power
 * cycles is the job of whatever sits behind these outputs.
 */
`timescale 1ns/1ps
`include "spcd_regs.vh"

module spcd_decoder #(
    parameter PAGE_AW   = 7,
    parameter WR_CYCLES = `SPCD_T_WR_US * `SPCD_CLK_MHZ,
    parameter ER_CYCLES = `SPCD_T_ERASE_US * `SPCD_CLK_MHZ
) (
    input  wire                 mclk,
    input  wire                 reset_n,
    input  wire                 prog_reset_n,
    input  wire                 prog_sck,
    input  wire                 prog_serial_in,
    output reg                  prog_serial_out,
    output reg  [7:0]           mem_ext_addr,
    output reg  [15:0]          mem_addr,
    output reg                  fbuf_we,
    output reg                  fbuf_hi,
    output reg  [PAGE_AW-1:0]   fbuf_idx,
    output reg  [7:0]           mem_wdata,
    output reg                  ebuf_we,
    output reg  [1:0]           ebuf_idx,
    output reg                  flash_page_wr,
    output reg                  ee_page_wr,
    output reg                  chip_erase,
    input  wire [7:0]           flash_rd_hi,
    input  wire [7:0]           flash_rd_lo,
    output reg  [7:0]           fuse_lo_r,
    output reg  [7:0]           fuse_hi_r,
    output reg  [7:0]           fuse_ext_r,
    output reg  [7:0]           lock_r,
    output reg                  prog_enabled_r,
    output wire                 busy_poll_flag
);

    localparam CNT_W = 30;

    // two-flop synchronisers for the link pins
    reg [1:0] sck_s_r;
    reg [1:0] sdi_s_r;
    reg [1:0] rst_s_r;
    reg       sck_d_r;
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sck_s_r <= 2'h0;
            sdi_s_r <= 2'h0;
            rst_s_r <= 2'h3;
            sck_d_r <= 1'b0;
        end else begin
            sck_s_r <= {sck_s_r[0], prog_sck};
            sdi_s_r <= {sdi_s_r[0], prog_serial_in};
            rst_s_r <= {rst_s_r[0], prog_reset_n};
            sck_d_r <= sck_s_r[1];
        end
    end

    wire sck_rise = sck_s_r[1] & ~sck_d_r;
    wire sck_fall = ~sck_s_r[1] & sck_d_r;
    wire in_prog  = ~rst_s_r[1];
    wire sdi      = sdi_s_r[1];

    // instruction shifter: 32 bits, msb first, framed by held reset
    reg [31:0] shift_r;
    reg [4:0]  bitcnt_r;
    reg        ans_ld_r;
    reg [7:0]  tx_r;
    reg [CNT_W-1:0] busy_cnt_r;

    wire [31:0] shift_nxt = {shift_r[30:0], sdi};
    wire [7:0]  b1 = shift_nxt[31:24];
    wire [7:0]  b2 = shift_nxt[23:16];
    wire [7:0]  b3 = shift_nxt[15:8];
    wire [7:0]  b4 = shift_nxt[7:0];
    wire        byte_end  = sck_rise & (bitcnt_r[2:0] == 3'h7);
    wire        instr_end = sck_rise & (bitcnt_r == 5'h1F);

    assign busy_poll_flag = (busy_cnt_r != {CNT_W{1'b0}});

    // answer byte for byte four, chosen one cycle after byte three lands:
    // the outside memory then answers for the new mem_addr, not the old one;
    // unknown opcodes answer zero
    reg [7:0] ans;
    always @* begin
        ans = 8'h00;
        case (shift_r[23:16])
            `SPCD_OP_POLL:    ans = {7'h00, busy_poll_flag};
            `SPCD_OP_RD_HI:   ans = flash_rd_hi;
            `SPCD_OP_RD_LO:   ans = flash_rd_lo;
            `SPCD_OP_RD_FUSE: ans = (shift_r[15:8] == `SPCD_SUB_FUSE_ALT) ?
                                    fuse_ext_r : fuse_lo_r;
            `SPCD_OP_RD_LOCK: ans = (shift_r[15:8] == `SPCD_SUB_FUSE_ALT) ?
                                    fuse_hi_r : lock_r;
            default:          ans = 8'h00;
        endcase
    end

    // frame position of the byte that has just completed
    localparam [1:0] BYTE_TWO   = 2'h1;
    localparam [1:0] BYTE_THREE = 2'h2;

    // byte boundaries inside the frame: end of byte two and of byte three
    wire echo_cyc    = byte_end & (bitcnt_r[4:3] == BYTE_TWO);
    wire rd_addr_cyc = byte_end & (bitcnt_r[4:3] == BYTE_THREE);

    // decode in the cycle the 32nd bit lands; every load and write but the enable
    // instruction is refused until enabled, and while a timed write runs,
    // because touching the arrays mid-write would corrupt them
    wire is_enable  = (b1 == `SPCD_OP_ENABLE) & (b2 == `SPCD_SUB_ENABLE);
    wire exec       = instr_end & in_prog & prog_enabled_r & ~busy_poll_flag;
    wire op_ld_ext  = exec & (b1 == `SPCD_OP_LD_EXT);
    wire op_ld_hi   = exec & (b1 == `SPCD_OP_LD_HI);
    wire op_ld_lo   = exec & (b1 == `SPCD_OP_LD_LO);
    wire op_ld_ee   = exec & (b1 == `SPCD_OP_LD_EE);
    wire op_wr_ee   = exec & (b1 == `SPCD_OP_WR_EE_PAGE);
    wire op_wr_page = exec & (b1 == `SPCD_OP_WR_PAGE);
    // instructions sharing the enable opcode, told apart by byte two
    wire op_special = exec & (b1 == `SPCD_OP_ENABLE);
    wire op_erase   = op_special & (b2 == `SPCD_SUB_ERASE);
    wire op_wr_lock = op_special & (b2 == `SPCD_SUB_WR_LOCK);
    wire op_wr_flo  = op_special & (b2 == `SPCD_SUB_WR_FLO);
    wire op_wr_fhi  = op_special & (b2 == `SPCD_SUB_WR_FHI);
    wire op_wr_fext = op_special & (b2 == `SPCD_SUB_WR_FEXT);

    // frame shifter and answer shifter; releasing the device reset pin
    // drops a half-received frame, which is how a programmer that lost
    // step gets back in line
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            shift_r  <= 32'h0;
            bitcnt_r <= 5'h0;
            ans_ld_r <= 1'b0;
            tx_r     <= 8'h00;
        end else if (!in_prog) begin
            shift_r  <= 32'h0;
            bitcnt_r <= 5'h0;
            ans_ld_r <= 1'b0;
            tx_r     <= 8'h00;
        end else begin
            ans_ld_r <= rd_addr_cyc;
            // one bit per synchronised rising edge, msb first
            if (sck_rise) begin
                shift_r  <= shift_nxt;
                bitcnt_r <= bitcnt_r + 5'h1;
                tx_r     <= {tx_r[6:0], 1'b0};
            end
            // byte two done: echo it while byte three shifts
            if (echo_cyc)
                tx_r <= shift_nxt[7:0];
            // memory has had one cycle to answer the new address
            if (ans_ld_r)
                tx_r <= ans;
        end
    end

    // the answer pin moves only after a falling clock edge, so the
    // programmer finds it settled at the next rise
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            prog_serial_out <= 1'b0;
        else if (sck_fall)
            prog_serial_out <= tx_r[7];
    end

    // enable latch: set by the enable instruction, cleared when the
    // device reset pin is released, so every session starts refused;
    // a wrong enable simply leaves it clear and the programmer retries
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            prog_enabled_r <= 1'b0;
        else if (!in_prog)
            prog_enabled_r <= 1'b0;
        else if (instr_end && is_enable)
            prog_enabled_r <= 1'b1;
    end

    // extended address byte: kept across pages and reads until reloaded,
    // so a programmer sets it once per upper region
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            mem_ext_addr <= 8'h00;
        else if (op_ld_ext)
            mem_ext_addr <= b3;
    end

    // addresses, indices and write data towards the outside memories
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mem_addr  <= 16'h0000;
            mem_wdata <= 8'h00;
            fbuf_hi   <= 1'b0;
            fbuf_idx  <= {PAGE_AW{1'b0}};
            ebuf_idx  <= 2'h0;
        end else begin
            // read address must stand before the answer byte is chosen
            if (in_prog && rd_addr_cyc)
                mem_addr <= shift_nxt[15:0];
            // write data follows byte four of every instruction
            if (in_prog && instr_end)
                mem_wdata <= b4;
            // flash buffer word: low bits of byte three pick the word
            if (op_ld_hi || op_ld_lo) begin
                fbuf_hi  <= op_ld_hi;
                fbuf_idx <= b3[PAGE_AW-1:0];
            end
            // eeprom buffer byte: only two bits of byte three count
            if (op_ld_ee)
                ebuf_idx <= b3[1:0];
            // eeprom page writes clear the bits that select within a page; flash page writes keep all of byte three
            if (op_wr_ee)
                mem_addr <= {b2, b3[7:2], 2'h0};
            if (op_wr_page)
                mem_addr <= {b2, b3};
        end
    end

    // one-cycle strobes towards the page buffers and memory arrays,
    // registered so the arrays never see a decode glitch
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            fbuf_we       <= 1'b0;
            ebuf_we       <= 1'b0;
            flash_page_wr <= 1'b0;
            ee_page_wr    <= 1'b0;
            chip_erase    <= 1'b0;
        end else begin
            fbuf_we       <= op_ld_hi | op_ld_lo;
            ebuf_we       <= op_ld_ee;
            flash_page_wr <= op_wr_page;
            ee_page_wr    <= op_wr_ee;
            chip_erase    <= op_erase;
        end
    end

    // fuse and lock bytes: a zero bit is programmed, a one unprogrammed;
    // the byte is kept as written, with no masking of unused bits, so
    // a readback shows exactly what the programmer sent
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            fuse_lo_r  <= `SPCD_FUSE_RST;
            fuse_hi_r  <= `SPCD_FUSE_RST;
            fuse_ext_r <= `SPCD_FUSE_RST;
            lock_r     <= `SPCD_FUSE_RST;
        end else begin
            if (op_wr_lock)
                lock_r <= b4;
            if (op_wr_flo)
                fuse_lo_r <= b4;
            if (op_wr_fhi)
                fuse_hi_r <= b4;
            if (op_wr_fext)
                fuse_ext_r <= b4;
        end
    end

    // self-timed busy: loaded by page writes and erase, counts to zero;
    // fuse and lock writes finish at once here, so they never raise it,
    // and nothing can reload it early because busy refuses all writes
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            busy_cnt_r <= {CNT_W{1'b0}};
        else if (op_wr_page || op_wr_ee)
            busy_cnt_r <= WR_CYCLES[CNT_W-1:0];
        else if (op_erase)
            busy_cnt_r <= ER_CYCLES[CNT_W-1:0];
        else if (busy_poll_flag)
            busy_cnt_r <= busy_cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
    end

endmodule // spcd_decoder

// ### verification/spcd_properties.sv
/* port checker for spcd_decoder: strobes, busy timing, output edge.
   assumes one mclk domain with reset_n async low; bound below. */
`timescale 1ns/1ps
module spcd_props (
    input wire        mclk,
    input wire        reset_n,
    input wire        prog_sck,
    input wire        prog_serial_out,
    input wire [7:0]  mem_ext_addr,
    input wire [15:0] mem_addr,
    input wire        fbuf_we,
    input wire        ee_page_wr,
    input wire        flash_page_wr,
    input wire        chip_erase,
    input wire [7:0]  fuse_lo_r,
    input wire        prog_enabled_r,
    input wire        busy_poll_flag
);
    // all checks share mclk; nothing is judged while reset holds
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    chk_fbuf_one_cycle: assert property (fbuf_we |=> !fbuf_we)
        else $error("flash buffer strobe longer than one cycle");
    chk_page_busy: assert property (flash_page_wr |-> ##2 busy_poll_flag [*8])
        else $error("busy not raised after page write");
    chk_erase_busy: assert property (chip_erase |-> ##2 busy_poll_flag [*8])
        else $error("busy not raised after chip erase");
    chk_ee_page_align: assert property (ee_page_wr |-> mem_addr[1:0] == 2'b00)
        else $error("eeprom page address not aligned");
    chk_strobe_enabled: assert property ((fbuf_we || ee_page_wr ||
        flash_page_wr || chip_erase) |-> prog_enabled_r)
        else $error("memory strobe without enable");
    chk_out_sck_low: assert property ($changed(prog_serial_out) |-> !prog_sck)
        else $error("serial out moved while clock high");
    chk_ext_addr_hold: assert property ($changed(mem_ext_addr) |-> $past(prog_enabled_r))
        else $error("extended address changed while disabled");
    chk_fuse_hold: assert property ($changed(fuse_lo_r) |-> $past(prog_enabled_r))
        else $error("fuse byte changed while disabled");
    chk_strobe_alone: assert property (flash_page_wr |-> !ee_page_wr && !chip_erase)
        else $error("page write overlaps another strobe");
endmodule // spcd_props

bind spcd_decoder spcd_props u_spcd_props (.mclk, .reset_n, .prog_sck, .prog_serial_out,
    .mem_ext_addr, .mem_addr, .fbuf_we, .ee_page_wr, .flash_page_wr, .chip_erase,
    .fuse_lo_r, .prog_enabled_r, .busy_poll_flag);

// ### verification/spcd_prog_model.sv
/* serial programmer model: frames four-byte instructions on the link.
   assumes the bench holds the device reset pin low around frames. */
`timescale 1ns/1ps
module spcd_prog_model (
    output reg  prog_sck,
    output reg  prog_serial_in,
    input  wire prog_serial_out
);
    integer i;
    // clock stands low outside frames
    initial begin
        prog_sck = 1'b0;
        prog_serial_in = 1'b0;
    end
    // 160 ns link period, data set while low, answer read at the rise
    task xfer(input [31:0] cmd, output [31:0] rsp);
        begin
            #3;
            for (i = 31; i >= 0; i = i - 1) begin
                prog_serial_in = cmd[i];
                #80 prog_sck = 1'b1;
                rsp = {rsp[30:0], prog_serial_out};
                #80 prog_sck = 1'b0;
            end
            prog_serial_in = ~prog_serial_in; // released line must not look held
        end
    endtask
endmodule // spcd_prog_model

// ### verification/test_spcd_decoder.sv
/* testbench for spcd_decoder with a programmer model on the link.
   assumes short write and erase timers so busy shows on one poll after a page write and on two after an erase. */
`timescale 1ns/1ps
module test_spcd_decoder;
    reg         mclk, reset_n, prog_reset_n;
    reg  [31:0] rsp;
    reg  [15:0] fb_cap, fp_cap, ep_cap;
    reg  [9:0]  eb_cap;
    wire        sck, sdi, sdo, busy, fbuf_we, fbuf_hi, ebuf_we, fpw, epw, cer, en;
    wire [6:0]  fbuf_idx;
    wire [1:0]  ebuf_idx;
    wire [7:0]  ext, wdata, f_lo, f_hi, f_ext, lock;
    wire [15:0] addr;
    integer     err_total, tests_run, cyc, k, n_cer;

    // memory stand-in: read data follows the address, so a stale address shows
    spcd_decoder #(.PAGE_AW(7), .WR_CYCLES(600), .ER_CYCLES(1200)) u_spcd_decoder (
        .mclk(mclk), .reset_n(reset_n), .prog_reset_n(prog_reset_n), .prog_sck(sck),
        .prog_serial_in(sdi), .prog_serial_out(sdo), .mem_ext_addr(ext), .mem_addr(addr),
        .fbuf_we(fbuf_we), .fbuf_hi(fbuf_hi), .fbuf_idx(fbuf_idx), .mem_wdata(wdata),
        .ebuf_we(ebuf_we), .ebuf_idx(ebuf_idx), .flash_page_wr(fpw), .ee_page_wr(epw),
        .chip_erase(cer), .flash_rd_hi(addr[15:8] ^ 8'h2E), .flash_rd_lo(addr[7:0] ^ 8'hF7),
        .fuse_lo_r(f_lo),
        .fuse_hi_r(f_hi), .fuse_ext_r(f_ext), .lock_r(lock), .prog_enabled_r(en),
        .busy_poll_flag(busy));
    spcd_prog_model u_spcd_prog_model (.prog_sck(sck), .prog_serial_in(sdi),
        .prog_serial_out(sdo));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // strobes last one cycle, so catch them here; the cycle ceiling cuts hangs
    always @(posedge mclk) begin
        if (fbuf_we) fb_cap <= {fbuf_hi, fbuf_idx, wdata};
        if (ebuf_we) eb_cap <= {ebuf_idx, wdata};
        if (fpw) fp_cap <= addr;
        if (epw) ep_cap <= addr;
        if (cer) n_cer <= n_cer + 1;
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_total = err_total + 1;
            end_of_test;
        end
    end
    task check(input [31:0] seen, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // one instruction, then let the synchronised strobes land
    task send(input [31:0] c);
        begin
            u_spcd_prog_model.xfer(c, rsp);
            repeat (2) @(posedge mclk);
            #1;
        end
    endtask
    task poll;
        begin
            send(32'hF0000000);
            for (k = k; rsp[0] !== 1'b0 && cyc < 50000; k = k) send(32'hF0000000);
            check(rsp[7:0], 8'h00);
        end
    endtask
    task t_refuse;
        begin
            send(32'h4D005500);
            check(ext, 8'h00);
        end
    endtask
    task t_enable;
        begin
            send(32'hAC530000);
            check(rsp[15:8], 8'h53);
            check(en, 1'b1);
        end
    endtask
    task t_fuse;
        reg [7:0]  v;
        reg [31:0] wsub;
        reg [63:0] rsub;
        integer    j;
        begin
            for (j = 0; j < 4; j = j + 1) begin
                v = 8'hFF ^ (8'h03 << j); // unused bits stay at one
                wsub = 32'hA0A8A4E0 >> (24 - 8 * j);
                rsub = 64'h5000580850085800 >> (48 - 16 * j);
                send({8'hAC, wsub[7:0], 8'h00, v});
                poll;
                send({rsub[15:0], 16'h0000});
                check(rsp[7:0], v);
            end
            check({f_lo, f_hi, f_ext, lock}, 32'hFCF9F3E7);
        end
    endtask
    task t_flash;
        begin
            send(32'h4D000200);
            check(ext, 8'h02);
            send(32'h400005A5); // low byte first
            check(fb_cap, 16'h05A5);
            send(32'h4800055A);
            check(fb_cap, 16'h855A);
            send(32'h4C123400);
            check(fp_cap, 16'h1234);
            send(32'hF0000000);
            check(rsp[7:0], 8'h01);
            poll;
            check(ext, 8'h02);
        end
    endtask
    task t_read;
        begin
            send(32'h28123400);
            check({addr, rsp[7:0]}, 24'h12343C);
            send(32'h20123400);
            check({ext, rsp[7:0]}, 16'h02C3);
        end
    endtask
    task t_ee;
        begin
            send(32'hC1000366);
            check(eb_cap, 10'h366);
            send(32'hC201F300);
            check(ep_cap, 16'h01F0);
            poll;
        end
    endtask
    task t_erase;
        begin
            send(32'hAC800000);
            check(n_cer, 1);
            check(busy, 1'b1);
            poll;
        end
    endtask
    task end_of_test;
        begin
            $display("mismatches %0d comparisons %0d", err_total, tests_run);
            if (err_total == 0 && tests_run > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    // reset, scenarios, then release the device reset pin
    initial begin
        {reset_n, prog_reset_n, fb_cap, fp_cap, ep_cap, eb_cap} = 60'h1;
        {err_total, tests_run, cyc, k, n_cer} = 160'h0;
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        prog_reset_n <= 1'b0;
        repeat (5) @(posedge mclk);
        t_refuse;
        t_enable;
        t_fuse;
        t_flash;
        t_read;
        t_ee;
        t_erase;
        @(posedge mclk);
        prog_reset_n <= 1'b1;
        repeat (5) @(posedge mclk);
        check(en, 1'b0);
        end_of_test;
    end
endmodule // test_spcd_decoder
